// ### lfmc_ctrl.sv
// Mode sequencer of a boost flash/torch LED driver with its register file.
// Assumes a byte register port behind the serial bus framing, and
// comparator levels synchronous to clk.
`timescale 1ns/10ps
module lfmc_ctrl
	import lfmc_pkg::*;
#(
	parameter int unsigned TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_CYC,
	parameter int unsigned LED_DELAY_CYCLES = LED_DELAY_CYC,
	parameter int unsigned OUT_DELAY_CYCLES = OUT_DELAY_CYC,
	parameter logic [7:0] REVISION_ID = 8'h5a
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic hw_flash_trigger,
	input wire logic pa_sync_input,
	input wire logic vin_below_undervoltage_lockout,
	input wire logic vin_below_input_voltage_flash_monitor,
	input wire logic die_over_temp,
	input wire logic vout_over_ovp,
	input wire logic vout_below_short,
	input wire logic vout_below_vin,
	input wire logic vout_precharged,
	input wire logic led_below_short,
	input wire logic headroom_low,
	input wire logic inductor_limit,
	output logic led_on,
	output logic [3:0] led_level,
	output logic led_torch_range,
	output logic lowside_enable,
	output logic highside_full_on,
	output logic highside_precharge,
	output logic highside_limit,
	output logic boost_mode
);
	// REVISION_ID value is arbitrary
	if (TIMEOUT_STEP_CYCLES < 1 ||
		TIMEOUT_STEP_CYCLES > 32'h1fff_ffff / TIMEOUT_LEVELS)
		$error("lfmc_ctrl: TIMEOUT_STEP_CYCLES out of range");
	if (LED_DELAY_CYCLES < 1 || OUT_DELAY_CYCLES < 1)
		$error("lfmc_ctrl: fault delays must be at least one cycle");

	lfmc_regs_type r, n;
	logic timer_start;
	logic timer_stop;
	logic timer_expired;
	logic [31:0] timeout_cycles;

	// ********************
	// Flash timeout timer
	// ********************
	assign timeout_cycles = 32'((int'(r.features[2:0]) + 1) *
		TIMEOUT_STEP_CYCLES);

	lfmc_timer #(
		.WIDTH(32)
	) u_timeout (
		.clk(clk),
		.reset(reset),
		.start(timer_start),
		.stop(timer_stop),
		.limit(timeout_cycles),
		.expired(timer_expired)
	);

	function automatic logic [3:0] torch_code(input logic [7:0] cur);
		torch_code = {1'b0, cur[6:4]};
	endfunction

	// ********************
	// Sequencer
	// ********************
	logic flash_req;
	logic torch_req;
	logic pa_cut;
	logic undervoltage_lockout_hit;
	logic led_fault;
	logic stop_all;
	logic flags_read;
	logic [3:0] target;
	logic [7:0] flag_set;

	always_comb
	begin
		n = r;
		flag_set = '0;
		stop_all = 1'b0;
		timer_start = 1'b0;
		flags_read = reg_rd && (reg_addr == ADDR_FLAGS);
		flash_req = (r.enable[1:0] == MODE_FLASH) ||
			(r.enable[EN_STROBE_PIN] && hw_flash_trigger &&
			!r.strobe_done);
		torch_req = (r.enable[1:0] == MODE_TORCH) ||
			(r.enable[EN_TORCH_PIN] && !r.enable[EN_PA_SYNC_PIN] &&
			pa_sync_input);
		pa_cut = r.enable[EN_PA_SYNC_PIN] && pa_sync_input;
		undervoltage_lockout_hit = r.input_voltage_flash_monitor_cfg[INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE] && vin_below_undervoltage_lockout;
		target = r.is_flash ? r.current[3:0] : torch_code(r.current);

		// Register port; read data registered one cycle after reg_rd
		if (reg_wr)
		begin
			case (reg_addr)
			ADDR_ENABLE: n.enable = reg_wdata & ENABLE_WMASK;
			ADDR_FEATURES: n.features = reg_wdata;
			ADDR_CURRENT: n.current = reg_wdata;
			ADDR_INPUT_VOLTAGE_FLASH_MONITOR: n.input_voltage_flash_monitor_cfg = reg_wdata;
			default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
			ADDR_REVISION: n.rdata = REVISION_ID;
			ADDR_INPUT_VOLTAGE_FLASH_MONITOR: n.rdata = r.input_voltage_flash_monitor_cfg;
			ADDR_FEATURES: n.rdata = r.features;
			ADDR_CURRENT: n.rdata = r.current;
			ADDR_ENABLE: n.rdata = r.enable;
			ADDR_FLAGS: n.rdata = r.flags;
			default: n.rdata = 8'h00;
			endcase
		end
		if (flags_read)
		begin
			n.flags = '0;
			n.hold = 1'b0;
		end
		if (!hw_flash_trigger)
			n.strobe_done = 1'b0;

		// Saturating time since the LED source was triggered
		if (r.state != ST_STANDBY && r.since_on != 32'hffff_ffff)
			n.since_on = r.since_on + 32'h0000_0001;

		led_fault = 1'b0;
		if (r.state == ST_ON)
		begin
			if (r.since_on >= 32'(LED_DELAY_CYCLES) && led_below_short)
				led_fault = 1'b1;
			if (r.since_on >= 32'(OUT_DELAY_CYCLES) &&
				(vout_over_ovp || vout_below_short))
				led_fault = 1'b1;
		end

		// Flags: set wins over the read clear, level re-sets only if present
		flag_set[FL_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_hit;
		flag_set[FL_THERMAL] = die_over_temp;
		flag_set[FL_OVERVOLT] = vout_over_ovp;
		flag_set[FL_LED_OUT] = led_fault;
		flag_set[FL_TIMEOUT] = timer_expired && r.is_flash &&
			r.state != ST_STANDBY;
		flag_set[FL_INPUT_VOLTAGE_FLASH_MONITOR] = r.state == ST_ON && r.is_flash &&
			r.enable[EN_INPUT_VOLTAGE_FLASH_MONITOR_HOLD] && vin_below_input_voltage_flash_monitor;

		case (r.state)
		ST_STANDBY:
		begin
			if (!r.hold && (flash_req || torch_req))
			begin
				n.is_flash = flash_req;
				timer_start = flash_req;
				n.since_on = '0;
				n.code = '0;
				n.step_cnt = '0;
				n.boost = 1'b0;
				if (vout_below_vin && !vout_precharged)
					n.state = ST_PRECHARGE;
				else
					n.state = ST_ON;
			end
		end
		ST_PRECHARGE:
		begin
			if (vout_precharged)
				n.state = ST_ON;
			if (!(r.is_flash ? flash_req : torch_req))
				stop_all = 1'b1;
		end
		ST_ON:
		begin
			if (headroom_low)
				n.boost = 1'b1;
			if (r.code != target)
			begin
				if (r.step_cnt == RAMP_STEP_CYC - 8'h01)
				begin
					n.step_cnt = '0;
					if (r.code > target)
						n.code = target;
					else if (!flag_set[FL_INPUT_VOLTAGE_FLASH_MONITOR])
						n.code = r.code + 4'h1;
				end
				else
					n.step_cnt = r.step_cnt + 8'h01;
			end
			if (!(r.is_flash ? flash_req : torch_req))
				stop_all = 1'b1;
		end
		default: n.state = ST_STANDBY;
		endcase

		// Faults that end operation and clear the mode bits
		if (flag_set[FL_TIMEOUT] || led_fault || undervoltage_lockout_hit ||
			die_over_temp)
		begin
			stop_all = 1'b1;
			n.enable[1:0] = MODE_STANDBY;
			n.strobe_done = n.strobe_done || flag_set[FL_TIMEOUT];
		end
		if (undervoltage_lockout_hit || die_over_temp)
			n.hold = 1'b1;
		if (stop_all || (r.hold && r.state != ST_STANDBY))
		begin
			n.state = ST_STANDBY;
			n.code = '0;
		end
		timer_stop = n.state == ST_STANDBY;

		n.flags = n.flags | flag_set;

		// ********************
		// Power stage controls, registered
		// ********************
		n.led_on = n.state == ST_ON;
		if (n.state == ST_ON && n.is_flash && pa_cut)
		begin
			n.level_out = torch_code(n.current);
			n.torch_range = 1'b1;
		end
		else
		begin
			n.level_out = n.led_on ? n.code : 4'h0;
			n.torch_range = !n.is_flash;
		end
		n.ls_en = n.state == ST_ON && n.boost && !vout_over_ovp &&
			!inductor_limit && !vout_below_short;
		n.hs_limit = n.state != ST_STANDBY && vout_below_short;
		n.hs_full = n.state == ST_ON && !n.boost && !vout_below_short;
		n.hs_pre = n.state == ST_PRECHARGE && !vout_below_short;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			r <= '0;
			r.state <= ST_STANDBY;
			r.enable <= RST_ENABLE;
			r.flags <= RST_FLAGS;
			r.features <= RST_FEATURES;
			r.current <= RST_CURRENT;
			r.input_voltage_flash_monitor_cfg <= RST_INPUT_VOLTAGE_FLASH_MONITOR;
		end
		else
			r <= n;
	end

	assign reg_rdata = r.rdata;
	assign led_on = r.led_on;
	assign led_level = r.level_out;
	assign led_torch_range = r.torch_range;
	assign lowside_enable = r.ls_en;
	assign highside_full_on = r.hs_full;
	assign highside_precharge = r.hs_pre;
	assign highside_limit = r.hs_limit;
	assign boost_mode = r.boost;

	// ********************
	// Checks
	// ********************
	sequence s_flash_on;
		r.state == ST_ON && r.is_flash && !r.hold;
	endsequence

	property p_pa_cut;
		@(posedge clk) disable iff (reset)
		(s_flash_on and (r.enable[EN_PA_SYNC_PIN] && pa_sync_input &&
		!timer_expired && !die_over_temp && !vin_below_undervoltage_lockout &&
		flash_req && !led_below_short && !vout_over_ovp &&
		!vout_below_short)) |=> (led_torch_range &&
		led_level == torch_code(r.current));
	endproperty
	a_pa_cut: assert property (p_pa_cut)
		else $error("pa sync did not force torch level");

	property p_pa_release;
		@(posedge clk) disable iff (reset)
		(led_on && r.is_flash && !pa_sync_input && led_torch_range &&
		r.state == ST_ON) |=> (!led_on || (!led_torch_range &&
		led_level == r.code));
	endproperty
	a_pa_release: assert property (p_pa_release)
		else $error("flash level not restored after pa sync release");

	property p_timeout;
		@(posedge clk) disable iff (reset)
		(timer_expired && r.is_flash && r.state != ST_STANDBY) |=>
		(!led_on && r.enable[1:0] == MODE_STANDBY && r.flags[FL_TIMEOUT]);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("flash timeout did not end flash");

	property p_input_voltage_flash_monitor_hold;
		@(posedge clk) disable iff (reset)
		(s_flash_on and (r.enable[EN_INPUT_VOLTAGE_FLASH_MONITOR_HOLD] && vin_below_input_voltage_flash_monitor &&
		r.code < target)) |=> (r.code <= $past(r.code));
	endproperty
	a_input_voltage_flash_monitor_hold: assert property (p_input_voltage_flash_monitor_hold)
		else $error("flash ramp moved during monitor hold");

	property p_undervoltage_lockout;
		@(posedge clk) disable iff (reset)
		(r.input_voltage_flash_monitor_cfg[INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE] && vin_below_undervoltage_lockout && !reg_wr) |=>
		(r.flags[FL_UNDERVOLTAGE_LOCKOUT] && r.hold && r.enable[1:0] == MODE_STANDBY)
		##1 (r.state == ST_STANDBY);
	endproperty
	a_undervoltage_lockout: assert property (p_undervoltage_lockout)
		else $error("undervoltage not handled");

	property p_undervoltage_lockout_off;
		@(posedge clk) disable iff (reset)
		(!r.input_voltage_flash_monitor_cfg[INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE] && !r.flags[FL_UNDERVOLTAGE_LOCKOUT]) |=>
		!r.flags[FL_UNDERVOLTAGE_LOCKOUT];
	endproperty
	a_undervoltage_lockout_off: assert property (p_undervoltage_lockout_off)
		else $error("undervoltage flagged while disabled");

	property p_thermal;
		@(posedge clk) disable iff (reset)
		die_over_temp |=> (r.flags[FL_THERMAL] && !lowside_enable &&
		!highside_full_on && !led_on && r.state == ST_STANDBY);
	endproperty
	a_thermal: assert property (p_thermal)
		else $error("thermal trip did not shut down");

	property p_hold_standby;
		@(posedge clk) disable iff (reset)
		(r.hold && !flags_read) |=> (r.state == ST_STANDBY) [*2];
	endproperty
	a_hold_standby: assert property (p_hold_standby)
		else $error("restart before flag read");

	property p_ovp_switch;
		@(posedge clk) disable iff (reset)
		vout_over_ovp |=> !lowside_enable;
	endproperty
	a_ovp_switch: assert property (p_ovp_switch)
		else $error("low-side switched during overvoltage");

	property p_led_delay;
		@(posedge clk) disable iff (reset)
		(r.state == ST_ON && r.since_on < 32'(LED_DELAY_CYCLES) &&
		!r.flags[FL_LED_OUT] && !flags_read) |=> !r.flags[FL_LED_OUT];
	endproperty
	a_led_delay: assert property (p_led_delay)
		else $error("LED fault before sampling delay");

	property p_flag_read;
		@(posedge clk) disable iff (reset)
		flags_read |=> (reg_rdata == $past(r.flags));
	endproperty
	a_flag_read: assert property (p_flag_read)
		else $error("flag read returned wrong value");
endmodule // lfmc_ctrl

// ### lfmc_pkg.sv
// Constants, register map and state types of the flash/torch mode controller.
// Assumes a 25 MHz core clock; analog comparators arrive as clean levels.
package lfmc_pkg;

	// ********************
	// Clock and times
	// ********************
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned TIMEOUT_STEP_MS = 100;
	localparam int unsigned TIMEOUT_STEP_CYC =
		(TIMEOUT_STEP_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LED_DELAY_NS = 256_000;
	localparam int unsigned LED_DELAY_CYC =
		(LED_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OUT_DELAY_US = 2048;
	localparam int unsigned OUT_DELAY_CYC =
		(OUT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RAMP_STEP_CYC = 8'h20;
	localparam int unsigned TIMEOUT_LEVELS = 8;

	// ********************
	// Register offsets and reset values
	// ********************
	localparam logic [7:0] ADDR_REVISION = 8'h00;
	localparam logic [7:0] ADDR_INPUT_VOLTAGE_FLASH_MONITOR = 8'h01;
	localparam logic [7:0] ADDR_FEATURES = 8'h08;
	localparam logic [7:0] ADDR_CURRENT = 8'h09;
	localparam logic [7:0] ADDR_ENABLE = 8'h0a;
	localparam logic [7:0] ADDR_FLAGS = 8'h0b;
	localparam logic [7:0] RST_INPUT_VOLTAGE_FLASH_MONITOR = 8'h80;
	localparam logic [7:0] RST_FEATURES = 8'h52;
	localparam logic [7:0] RST_CURRENT = 8'h0f;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] ENABLE_WMASK = 8'hf3;

	// ********************
	// Field positions
	// ********************
	localparam int EN_MODE_LO = 0;
	localparam int EN_TORCH_PIN = 4;
	localparam int EN_STROBE_PIN = 5;
	localparam int EN_PA_SYNC_PIN = 6;
	localparam int EN_INPUT_VOLTAGE_FLASH_MONITOR_HOLD = 7;
	localparam int INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE = 7;
	localparam int FL_TIMEOUT = 0;
	localparam int FL_THERMAL = 1;
	localparam int FL_LED_OUT = 2;
	localparam int FL_OVERVOLT = 3;
	localparam int FL_UNDERVOLTAGE_LOCKOUT = 4;
	localparam int FL_INPUT_VOLTAGE_FLASH_MONITOR = 5;
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_TORCH = 2'h2;
	localparam logic [1:0] MODE_FLASH = 2'h3;

	typedef enum logic [2:0] {
		ST_STANDBY = 3'b001,
		ST_PRECHARGE = 3'b010,
		ST_ON = 3'b100
	} lfmc_state_type;

	typedef struct packed {
		lfmc_state_type state;
		logic [7:0] enable;
		logic [7:0] flags;
		logic [7:0] features;
		logic [7:0] current;
		logic [7:0] input_voltage_flash_monitor_cfg;
		logic [7:0] rdata;
		logic [3:0] code;
		logic [7:0] step_cnt;
		logic [31:0] since_on;
		logic is_flash;
		logic hold;
		logic strobe_done;
		logic boost;
		logic [3:0] level_out;
		logic torch_range;
		logic led_on;
		logic ls_en;
		logic hs_full;
		logic hs_pre;
		logic hs_limit;
	} lfmc_regs_type;

endpackage

// ### lfmc_timer.sv
// One-shot cycle timer with a one-cycle expiry pulse.
// Assumes synchronous requests: start as a single-cycle pulse, stop as a level that may be held.
`timescale 1ns/10ps
module lfmc_timer
	import lfmc_pkg::*;
#(
	parameter int unsigned WIDTH = 32
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic stop,
	input wire logic [WIDTH-1:0] limit,
	output logic expired
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic running;
		logic expired;
	} lfmc_tmr_type;

	lfmc_tmr_type r, n;

	if (WIDTH < 2)
		$error("lfmc_timer: WIDTH too small");

	always_comb
	begin
		n = r;
		n.expired = 1'b0;
		if (start)
		begin
			n.count = '0;
			n.running = 1'b1;
		end
		else if (stop)
			n.running = 1'b0;
		else if (r.running)
		begin
			if (r.count == limit - 1'b1)
			begin
				n.running = 1'b0;
				n.expired = 1'b1;
			end
			else
				n.count = r.count + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			r <= '0;
		else
			r <= n;
	end

	assign expired = r.expired;
endmodule // lfmc_timer

// ### lfmc_host.sv
// Host model standing in for the serial bus master of the controller.
// Assumes tasks are entered just after a rising edge of clk.
`timescale 1ns/10ps
module lfmc_host
	import lfmc_pkg::*;
(
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Released lines show the inverse so stale values are never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge clk);
	end
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	end
	endtask
endmodule // lfmc_host

// ### test_led_flash_mode_controller.sv
// Self-checking bench of the flash/torch mode controller.
// Assumes shortened timers; comparators are driven as plain levels.
`timescale 1ns/10ps
module test_led_flash_mode_controller
	import lfmc_pkg::*;
;
	localparam int TSTEP = 50;
	localparam logic [7:0] REV = 8'ha5; // Arbitrary revision code
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic trig = 1'b0, pa = 1'b0, uv = 1'b0, iv = 1'b0, hot = 1'b0;
	logic output_overvoltage = 1'b0, vshort = 1'b0, vlow = 1'b0, vpre = 1'b0;
	logic lshort = 1'b0, hr = 1'b0, ilim = 1'b0;
	logic [7:0] addr, wdata, rdata, d, lvl, lvl_q;
	logic wr, rd, led_on, torch, ls, hs_full, hs_pre, hs_lim, boost, torch_q;
	logic [3:0] level;
	logic [31:0] seed = 32'h0000_5256;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	int i, n;
	logic [7:0] ra [7] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h3c};
	logic [7:0] rv [7] = '{REV, 8'h80, 8'h52, 8'h0f, 8'h00, 8'h00, 8'h00};

	always #20 clk = ~clk;

	lfmc_ctrl #(.TIMEOUT_STEP_CYCLES(TSTEP), .LED_DELAY_CYCLES(8),
		.OUT_DELAY_CYCLES(16), .REVISION_ID(REV)) uut (.clk(clk),
		.reset(reset),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .hw_flash_trigger(trig), .pa_sync_input(pa),
		.vin_below_undervoltage_lockout(uv), .vin_below_input_voltage_flash_monitor(iv), .die_over_temp(hot),
		.vout_over_ovp(output_overvoltage), .vout_below_short(vshort),
		.vout_below_vin(vlow), .vout_precharged(vpre),
		.led_below_short(lshort), .headroom_low(hr), .inductor_limit(ilim),
		.led_on(led_on), .led_level(level), .led_torch_range(torch),
		.lowside_enable(ls), .highside_full_on(hs_full),
		.highside_precharge(hs_pre), .highside_limit(hs_lim),
		.boost_mode(boost));

	lfmc_host u_host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int exp_to(input int sel);
		exp_to = (sel + 1) * TSTEP;
	endfunction

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
	begin
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask

	task automatic chb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask

	task automatic wait_led(input logic v, input int lim);
		int k;
	begin
		k = 0;
		while (led_on !== v && k < lim)
		begin
			@(posedge clk);
			k++;
		end
		chb(led_on, v);
	end
	endtask

	task automatic complete_run;
	begin
		$display("Mismatches %0d, comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	// ********************
	// Watchdog and ramp monitor
	// ********************
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		lvl_q <= {4'h0, level};
		torch_q <= torch;
		// Flash and torch codes are different scales; compare like with like
		if (!reset && led_on === 1'b1 && torch === torch_q &&
			{4'h0, level} > lvl_q + 8'h01)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, level, lvl_q);
		end
		if (cyc == 30000)
		begin
			err_total++;
			complete_run();
		end
	end

	// ********************
	// Main sequence
	// ********************
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 7; i++)
		begin
			u_host.rd(ra[i], d);
			chk(d, rv[i]);
		end
		u_host.wr(8'h0a, 8'h0c);
		u_host.rd(8'h0a, d);
		chk(d, 8'h00);
		// Every timeout length; odd ones run with the sync pin held high
		for (i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			u_host.wr(8'h09, {1'b0, seed[6:0]});
			u_host.wr(8'h08, {5'b01010, i[2:0]});
			pa <= i[0];
			u_host.wr(8'h0a, i[0] ? 8'h43 : 8'h03);
			wait_led(1'b1, 4);
			n = 0;
			while (led_on === 1'b1 && n < 1000)
			begin
				@(posedge clk);
				n++;
			end
			chb(n > exp_to(i) - 5 && n < exp_to(i) + 5, 1'b1);
			chb(led_on, 1'b0);
			pa <= 1'b0;
			u_host.rd(8'h0a, d);
			chk(d & 8'h03, 8'h00);
			u_host.rd(8'h0b, d);
			chk(d, 8'h01);
		end
		u_host.wr(8'h09, 8'h52);
		u_host.wr(8'h0a, 8'h43);
		wait_led(1'b1, 4);
		repeat (80) @(posedge clk);
		pa <= 1'b1;
		repeat (10) @(posedge clk);
		chb(torch, 1'b1);
		pa <= 1'b0;
		repeat (70) @(posedge clk);
		chb(torch, 1'b0);
		chk({4'h0, level}, 8'h02);
		wait_led(1'b0, 400);
		u_host.rd(8'h0b, d);
		// Torch: output short, long run, boost, current limit, overvoltage
		u_host.wr(8'h0a, 8'h02);
		wait_led(1'b1, 4);
		chb(hs_full, 1'b1);
		vshort <= 1'b1;
		repeat (3) @(posedge clk);
		chb(hs_lim, 1'b1);
		chb(ls, 1'b0);
		vshort <= 1'b0;
		repeat (450) @(posedge clk);
		chb(led_on, 1'b1);
		hr <= 1'b1;
		repeat (4) @(posedge clk);
		chb(boost, 1'b1);
		chb(ls, 1'b1);
		ilim <= 1'b1;
		repeat (2) @(posedge clk);
		chb(ls, 1'b0);
		ilim <= 1'b0;
		u_host.rd(8'h0a, d);
		chk(d, 8'h02);
		chb(ls, 1'b1);
		output_overvoltage <= 1'b1;
		repeat (3) @(posedge clk);
		chb(ls, 1'b0);
		output_overvoltage <= 1'b0;
		hr <= 1'b0;
		u_host.rd(8'h0b, d);
		chk(d, 8'h0c);
		u_host.rd(8'h0a, d);
		chk(d, 8'h00);
		u_host.rd(8'h0b, d);
		chk(d, 8'h00);
		// LED node short, sampled only after its delay
		lshort <= 1'b1;
		u_host.wr(8'h0a, 8'h02);
		wait_led(1'b1, 4);
		repeat (4) @(posedge clk);
		chb(led_on, 1'b1);
		wait_led(1'b0, 20);
		lshort <= 1'b0;
		u_host.rd(8'h0b, d);
		chk(d, 8'h04);
		// Overtemperature with restart hold-off
		u_host.wr(8'h0a, 8'h02);
		wait_led(1'b1, 4);
		hot <= 1'b1;
		wait_led(1'b0, 4);
		chb(hs_full | ls, 1'b0);
		u_host.rd(8'h0a, d);
		chk(d, 8'h00);
		u_host.rd(8'h0b, d);
		chk(d, 8'h02);
		u_host.rd(8'h0b, d);
		chk(d, 8'h02);
		hot <= 1'b0;
		u_host.wr(8'h0a, 8'h02);
		repeat (5) @(posedge clk);
		chb(led_on, 1'b0);
		u_host.rd(8'h0b, d);
		wait_led(1'b1, 6);
		// Undervoltage, then with lockout disabled
		uv <= 1'b1;
		wait_led(1'b0, 4);
		uv <= 1'b0;
		u_host.wr(8'h0a, 8'h02);
		repeat (5) @(posedge clk);
		chb(led_on, 1'b0);
		u_host.rd(8'h0b, d);
		chk(d, 8'h10);
		wait_led(1'b1, 6);
		u_host.wr(8'h01, 8'h00);
		uv <= 1'b1;
		repeat (5) @(posedge clk);
		chb(led_on, 1'b1);
		uv <= 1'b0;
		u_host.rd(8'h0b, d);
		chk(d, 8'h00);
		u_host.wr(8'h0a, 8'h00);
		u_host.wr(8'h01, 8'h80);
		// Precharge before the LED source lights
		vlow <= 1'b1;
		u_host.wr(8'h0a, 8'h02);
		repeat (4) @(posedge clk);
		chb(hs_pre, 1'b1);
		chb(led_on, 1'b0);
		vpre <= 1'b1;
		wait_led(1'b1, 4);
		vlow <= 1'b0;
		u_host.wr(8'h0a, 8'h00);
		vpre <= 1'b0;
		// Trigger pin flash with stop-and-hold on the input monitor
		u_host.wr(8'h09, 8'h0f);
		u_host.wr(8'h08, 8'h57);
		u_host.wr(8'h0a, 8'ha0);
		trig <= 1'b1;
		wait_led(1'b1, 6);
		// Let the ramp climb a few codes before the monitor trips
		repeat (100) @(posedge clk);
		iv <= 1'b1;
		repeat (2) @(posedge clk);
		lvl = {4'h0, level};
		repeat (100) @(posedge clk);
		chk({4'h0, level}, lvl);
		chb(lvl != 8'h00, 1'b1);
		wait_led(1'b0, 400);
		trig <= 1'b0;
		iv <= 1'b0;
		u_host.rd(8'h0b, d);
		chk(d, 8'h21);
		complete_run();
	end
endmodule // test_led_flash_mode_controller
